//--- logic/fde_defines.svh
`ifndef FDE_DEFINES_SVH
`define FDE_DEFINES_SVH

// Register byte addresses on the plain register port
`define FDE_ADDR_W           8
`define FDE_OFS_HARD_CAUSE   8'h00
`define FDE_OFS_MEM_CAUSE    8'h04
`define FDE_OFS_BUS_CAUSE    8'h08
`define FDE_OFS_USAGE_CAUSE  8'h0c
`define FDE_OFS_MEM_ADDR     8'h10
`define FDE_OFS_BUS_ADDR     8'h14
`define FDE_OFS_CONTROL      8'h18
`define FDE_OFS_PRIORITY     8'h1c
`define FDE_OFS_STATE        8'h20

// Priority width and fixed levels (lower value is more urgent)
`define FDE_PRIO_W           8
`define FDE_PRIO_IDLE        8'hff
`define FDE_PRIO_HARD        8'h00

// Hard fault cause bits
`define FDE_HF_VECTOR        1
`define FDE_HF_ESCALATED     30

// Bus fault cause bits
`define FDE_BF_PREFETCH      0
`define FDE_BF_EXACT         1
`define FDE_BF_DEFERRED      2
`define FDE_BF_POP           3
`define FDE_BF_PUSH          4
`define FDE_BF_ADDR_VALID    7

// Memory management cause bits
`define FDE_MM_NOEXEC        0
`define FDE_MM_DATA          1
`define FDE_MM_ADDR_VALID    7

// Usage fault cause bits
`define FDE_UF_UNDEF         0
`define FDE_UF_STATE         1
`define FDE_UF_RETURN        2
`define FDE_UF_COPROC        3
`define FDE_UF_UNALIGNED     8
`define FDE_UF_DIVZERO       9
`define FDE_UF_W             10

// Control register fields
`define FDE_CTL_MEM_EN       0
`define FDE_CTL_BUS_EN       1
`define FDE_CTL_USAGE_EN     2

// Priority register byte lanes
`define FDE_PR_MEM_LSB       0
`define FDE_PR_BUS_LSB       8
`define FDE_PR_USAGE_LSB     16
`define FDE_PR_MASK_LSB      24

`endif

//--- logic/fde_fault_unit.sv
`timescale 1ns/1ps
`include "fde_defines.svh"

module fde_fault_unit (
    // Clock and reset
    input  wire logic                     i_clock,
    input  wire logic                     i_rst,
    // Register port
    input  wire logic [`FDE_ADDR_W-1:0]   i_reg_addr,
    input  wire logic [31:0]              i_reg_wdata,
    input  wire logic                     i_reg_write,
    input  wire logic                     i_reg_read,
    output logic      [31:0]              o_reg_rdata,
    // Bus error reports from the core and system bus
    input  wire logic                     i_err_vector_read,
    input  wire logic                     i_err_prefetch,
    input  wire logic                     i_err_exact_data,
    input  wire logic                     i_err_deferred_data,
    input  wire logic                     i_err_push,
    input  wire logic                     i_err_pop,
    input  wire logic [31:0]              i_bus_err_addr,
    // Internal error reports from the core
    input  wire logic                     i_err_undefined,
    input  wire logic                     i_err_set_switch,
    input  wire logic                     i_err_bad_return,
    input  wire logic                     i_err_coproc,
    input  wire logic                     i_err_unaligned,
    input  wire logic                     i_err_divzero,
    // Access rights reports
    input  wire logic                     i_err_no_execute,
    input  wire logic                     i_err_mem_data,
    input  wire logic [31:0]              i_mem_err_addr,
    // Exception state from the priority logic
    input  wire logic [`FDE_PRIO_W-1:0]   i_active_prio,
    input  wire logic [2:0]               i_active_kind,
    input  wire logic                     i_in_nmi,
    input  wire logic                     i_fault_ack,
    // Fault request to the exception entry logic
    output logic                          o_fault_req,
    output logic      [2:0]               o_fault_kind,
    output logic      [`FDE_PRIO_W-1:0]   o_fault_prio,
    output logic                          o_fault_escalated,
    // Lockup
    output logic                          o_lockup
);

    // Decoded handler kinds
    localparam logic [2:0] KIND_MEM   = 3'(fde_pkg::FDE_KIND_MEM);
    localparam logic [2:0] KIND_BUS   = 3'(fde_pkg::FDE_KIND_BUS);
    localparam logic [2:0] KIND_USAGE = 3'(fde_pkg::FDE_KIND_USAGE);
    localparam logic [2:0] KIND_HARD  = 3'(fde_pkg::FDE_KIND_HARD);
    localparam logic [2:0] KIND_NONE  = 3'(fde_pkg::FDE_KIND_NONE);

    // Register storage
    logic [2:0]              ctrl_reg;
    logic [31:0]             prio_reg;
    logic [31:0]             mem_addr_reg;
    logic [31:0]             bus_addr_reg;
    logic [31:0]             rdata_reg;
    logic                    req_reg;
    logic [2:0]              kind_reg;
    logic [`FDE_PRIO_W-1:0]  pprio_reg;
    logic                    esc_reg;
    fde_pkg::fde_state_t     state_reg;
    fde_pkg::fde_state_t     state_next;

    // Flag banks
    logic [31:0]             hard_set;
    logic [31:0]             hard_clr;
    logic [31:0]             hard_flags;
    logic [7:0]              mem_set;
    logic [7:0]              mem_clr;
    logic [7:0]              mem_flags;
    logic [7:0]              bus_set;
    logic [7:0]              bus_clr;
    logic [7:0]              bus_flags;
    logic [`FDE_UF_W-1:0]    use_set;
    logic [`FDE_UF_W-1:0]    use_clr;
    logic [`FDE_UF_W-1:0]    use_flags;

    // Relation of a new fault to what is running
    function automatic logic must_escalate(
        input logic                    en,
        input logic [`FDE_PRIO_W-1:0]  prio,
        input logic [2:0]              kind,
        input logic [`FDE_PRIO_W-1:0]  act_prio,
        input logic [2:0]              act_kind
    );
        logic same_kind;
        logic not_higher;
        same_kind  = (kind == act_kind);
        not_higher = (prio >= act_prio);
        return !en || same_kind || not_higher;
    endfunction

    // Register write decode
    logic wr_hard;
    logic wr_mem;
    logic wr_bus;
    logic wr_use;
    logic wr_ctrl;
    logic wr_prio;
    assign wr_hard = i_reg_write && (i_reg_addr == `FDE_OFS_HARD_CAUSE);
    assign wr_mem  = i_reg_write && (i_reg_addr == `FDE_OFS_MEM_CAUSE);
    assign wr_bus  = i_reg_write && (i_reg_addr == `FDE_OFS_BUS_CAUSE);
    assign wr_use  = i_reg_write && (i_reg_addr == `FDE_OFS_USAGE_CAUSE);
    assign wr_ctrl = i_reg_write && (i_reg_addr == `FDE_OFS_CONTROL);
    assign wr_prio = i_reg_write && (i_reg_addr == `FDE_OFS_PRIORITY);

    // Programmed priorities and mask
    logic [`FDE_PRIO_W-1:0] mem_prio;
    logic [`FDE_PRIO_W-1:0] bus_prio;
    logic [`FDE_PRIO_W-1:0] use_prio;
    logic [`FDE_PRIO_W-1:0] mask_prio;
    assign mem_prio  = prio_reg[`FDE_PR_MEM_LSB +: `FDE_PRIO_W];
    assign bus_prio  = prio_reg[`FDE_PR_BUS_LSB +: `FDE_PRIO_W];
    assign use_prio  = prio_reg[`FDE_PR_USAGE_LSB +: `FDE_PRIO_W];
    assign mask_prio = prio_reg[`FDE_PR_MASK_LSB +: `FDE_PRIO_W];

    // Fault sources grouped by handler
    logic mem_hit;
    logic bus_hit;
    logic bus_hit_esc;
    logic use_hit;
    logic hard_direct;
    assign mem_hit     = i_err_no_execute || i_err_mem_data;
    assign bus_hit     = i_err_prefetch || i_err_exact_data || i_err_deferred_data
                         || i_err_push || i_err_pop;
    // Push error on entry to own handler runs the bus handler anyway
    assign bus_hit_esc = bus_hit && !(i_err_push && i_active_kind == KIND_BUS
                         && !(i_err_prefetch || i_err_exact_data || i_err_deferred_data
                         || i_err_pop));
    assign use_hit     = i_err_undefined || i_err_set_switch || i_err_bad_return
                         || i_err_coproc || i_err_unaligned || i_err_divzero;
    assign hard_direct = i_err_vector_read;

    // Escalation per handler
    logic mem_esc;
    logic bus_esc;
    logic use_esc;
    logic any_esc;
    logic in_hard;
    assign mem_esc = mem_hit && must_escalate(ctrl_reg[`FDE_CTL_MEM_EN], mem_prio, KIND_MEM,
                                              i_active_prio, i_active_kind);
    assign bus_esc = bus_hit_esc && must_escalate(ctrl_reg[`FDE_CTL_BUS_EN], bus_prio, KIND_BUS,
                                                  i_active_prio, i_active_kind);
    assign use_esc = use_hit && must_escalate(ctrl_reg[`FDE_CTL_USAGE_EN], use_prio, KIND_USAGE,
                                              i_active_prio, i_active_kind);
    assign any_esc = mem_esc || bus_esc || use_esc;
    assign in_hard = (i_active_kind == KIND_HARD);

    // Winning handler: hard first, then most urgent configurable one
    logic                   go_hard;
    logic [2:0]             win_kind;
    logic [`FDE_PRIO_W-1:0] win_prio;
    logic                   new_fault;
    assign go_hard   = hard_direct || any_esc;
    assign new_fault = go_hard || mem_hit || bus_hit || use_hit;
    always_comb begin
        win_kind = KIND_NONE;
        win_prio = `FDE_PRIO_IDLE;
        if (go_hard) begin
            win_kind = KIND_HARD;
            win_prio = `FDE_PRIO_HARD;
        end else begin
            if (use_hit) begin
                win_kind = KIND_USAGE;
                win_prio = use_prio;
            end
            if (bus_hit && bus_prio <= win_prio) begin
                win_kind = KIND_BUS;
                win_prio = bus_prio;
            end
            if (mem_hit && mem_prio <= win_prio) begin
                win_kind = KIND_MEM;
                win_prio = mem_prio;
            end
        end
    end

    // Lockup entry: hard fault while the hard handler runs or NMI runs
    logic lock_hit;
    assign lock_hit = go_hard && (in_hard || i_in_nmi);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            fde_pkg::FDE_ST_RUN: begin
                if (lock_hit) begin
                    state_next = fde_pkg::FDE_ST_LOCK;
                end
            end
            fde_pkg::FDE_ST_LOCK: begin
                state_next = fde_pkg::FDE_ST_LOCK;
            end
        endcase
    end

    // Cause flag sets, one per cause
    always_comb begin
        hard_set = '0;
        hard_set[`FDE_HF_VECTOR]    = i_err_vector_read;
        hard_set[`FDE_HF_ESCALATED] = any_esc;
        mem_set = '0;
        mem_set[`FDE_MM_NOEXEC]     = i_err_no_execute;
        mem_set[`FDE_MM_DATA]       = i_err_mem_data;
        mem_set[`FDE_MM_ADDR_VALID] = mem_hit;
        bus_set = '0;
        bus_set[`FDE_BF_PREFETCH]   = i_err_prefetch;
        bus_set[`FDE_BF_EXACT]      = i_err_exact_data;
        bus_set[`FDE_BF_DEFERRED]   = i_err_deferred_data;
        bus_set[`FDE_BF_POP]        = i_err_pop;
        bus_set[`FDE_BF_PUSH]       = i_err_push;
        bus_set[`FDE_BF_ADDR_VALID] = i_err_exact_data;
        use_set = '0;
        use_set[`FDE_UF_UNDEF]      = i_err_undefined;
        use_set[`FDE_UF_STATE]      = i_err_set_switch;
        use_set[`FDE_UF_RETURN]     = i_err_bad_return;
        use_set[`FDE_UF_COPROC]     = i_err_coproc;
        use_set[`FDE_UF_UNALIGNED]  = i_err_unaligned;
        use_set[`FDE_UF_DIVZERO]    = i_err_divzero;
    end

    // Write one to clear
    assign hard_clr = wr_hard ? i_reg_wdata : '0;
    assign mem_clr  = wr_mem ? i_reg_wdata[7:0] : '0;
    assign bus_clr  = wr_bus ? i_reg_wdata[7:0] : '0;
    assign use_clr  = wr_use ? i_reg_wdata[`FDE_UF_W-1:0] : '0;

    // Sticky banks, one instance per status register
    fde_sticky_flags #(.WIDTH(32)) u_hard (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_set   (hard_set),
        .i_clear (hard_clr),
        .o_flags (hard_flags)
    );
    fde_sticky_flags #(.WIDTH(8)) u_mem (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_set   (mem_set),
        .i_clear (mem_clr),
        .o_flags (mem_flags)
    );
    fde_sticky_flags #(.WIDTH(8)) u_bus (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_set   (bus_set),
        .i_clear (bus_clr),
        .o_flags (bus_flags)
    );
    fde_sticky_flags #(.WIDTH(`FDE_UF_W)) u_use (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_set   (use_set),
        .i_clear (use_clr),
        .o_flags (use_flags)
    );

    // Pending request may be taken: above mask unless hard, strictly above the running level
    logic                   take_ok;
    logic [`FDE_PRIO_W-1:0] pend_prio_eff;
    assign pend_prio_eff = pprio_reg;
    assign take_ok = req_reg && (state_reg == fde_pkg::FDE_ST_RUN)
                     && (pend_prio_eff < mask_prio || kind_reg == KIND_HARD)
                     && (pend_prio_eff < i_active_prio)
                     && !i_in_nmi
                     && !(in_hard && kind_reg == KIND_HARD);

    // Configuration and control registers
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            ctrl_reg <= '0;
            prio_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= i_reg_wdata[2:0];
            end
            if (wr_prio) begin
                prio_reg <= i_reg_wdata;
            end
        end
    end

    // Fault address capture; first fault wins until its valid flag is cleared
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mem_addr_reg <= '0;
            bus_addr_reg <= '0;
        end else begin
            // A clear of the valid flag in the same cycle must not leave a stale address behind it
            if (mem_hit && (!mem_flags[`FDE_MM_ADDR_VALID] || mem_clr[`FDE_MM_ADDR_VALID])) begin
                mem_addr_reg <= i_mem_err_addr;
            end
            if (i_err_exact_data && (!bus_flags[`FDE_BF_ADDR_VALID] || bus_clr[`FDE_BF_ADDR_VALID])) begin
                bus_addr_reg <= i_bus_err_addr;
            end
        end
    end

    // Pending fault request; a hard fault overrides a weaker pending one
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            req_reg   <= 1'b0;
            kind_reg  <= KIND_NONE;
            pprio_reg <= `FDE_PRIO_IDLE;
            esc_reg   <= 1'b0;
        end else if (state_next == fde_pkg::FDE_ST_LOCK) begin
            req_reg   <= 1'b0;
        end else if (new_fault && (!req_reg || win_prio < pprio_reg)) begin
            req_reg   <= 1'b1;
            kind_reg  <= win_kind;
            pprio_reg <= win_prio;
            esc_reg   <= any_esc;
        end else if (i_fault_ack && take_ok) begin
            req_reg   <= 1'b0;
            esc_reg   <= 1'b0;
        end
    end

    // Run state
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_reg <= fde_pkg::FDE_ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        unique case (i_reg_addr)
            `FDE_OFS_HARD_CAUSE:  rd_mux = hard_flags;
            `FDE_OFS_MEM_CAUSE:   rd_mux = {24'h000000, mem_flags};
            `FDE_OFS_BUS_CAUSE:   rd_mux = {24'h000000, bus_flags};
            `FDE_OFS_USAGE_CAUSE: rd_mux = {22'h0, use_flags};
            `FDE_OFS_MEM_ADDR:    rd_mux = mem_addr_reg;
            `FDE_OFS_BUS_ADDR:    rd_mux = bus_addr_reg;
            `FDE_OFS_CONTROL:     rd_mux = {29'h0, ctrl_reg};
            `FDE_OFS_PRIORITY:    rd_mux = prio_reg;
            `FDE_OFS_STATE:       rd_mux = {31'h0, state_reg == fde_pkg::FDE_ST_LOCK};
            default:              rd_mux = 32'h00000000;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= i_reg_read ? rd_mux : 32'h00000000;
        end
    end

    // Outputs
    assign o_reg_rdata       = rdata_reg;
    assign o_fault_req       = take_ok;
    assign o_fault_kind      = kind_reg;
    assign o_fault_prio      = pprio_reg;
    assign o_fault_escalated = esc_reg;
    assign o_lockup          = (state_reg == fde_pkg::FDE_ST_LOCK);

endmodule

//--- logic/fde_pkg.sv
package fde_pkg;

    // Which handler a fault goes to
    typedef enum logic [2:0] {
        FDE_KIND_NONE  = 3'b000,
        FDE_KIND_MEM   = 3'b001,
        FDE_KIND_BUS   = 3'b010,
        FDE_KIND_USAGE = 3'b011,
        FDE_KIND_HARD  = 3'b100
    } fde_kind_t;

    // Core run state
    typedef enum logic [0:0] {
        FDE_ST_RUN  = 1'b0,
        FDE_ST_LOCK = 1'b1
    } fde_state_t;

endpackage

//--- logic/fde_sticky_flags.sv
`timescale 1ns/1ps

// Bank of sticky cause flags; set beats a write-one-to-clear in the same cycle
module fde_sticky_flags #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    // Set and clear
    input  wire logic [WIDTH-1:0] i_set,
    input  wire logic [WIDTH-1:0] i_clear,
    // Flags
    output logic      [WIDTH-1:0] o_flags
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    // Set wins so no event is lost
    assign flags_next = (flags_reg & ~i_clear) | i_set;
    assign o_flags    = flags_reg;

    // Flag storage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

endmodule

//--- sim/fde_core_model.sv
`timescale 1ns/1ps

// Exception entry side; stall lets a request wait before it is taken
module fde_core_model (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rst,
    // Request and controls
    input  wire logic       i_req,
    input  wire logic [2:0] i_kind,
    input  wire logic [7:0] i_prio,
    input  wire logic [31:0] i_stall,
    input  wire logic       i_ret,
    // Running exception
    output logic            o_ack,
    output logic      [2:0] o_act_kind,
    output logic      [7:0] o_act_prio
);
    int cnt;

    // Enter handler on a taken request; return goes straight to thread
    always @(posedge i_clock) begin
        if (i_rst || i_ret) begin
            o_ack <= 1'b0;
            o_act_kind <= 3'h0;
            o_act_prio <= 8'hff;
            cnt <= 0;
        end else if (o_ack && i_req) begin
            o_ack <= 1'b0;
            o_act_kind <= i_kind;
            o_act_prio <= i_prio;
            cnt <= 0;
        end else begin
            o_ack <= i_req && (cnt >= i_stall);
            cnt <= i_req ? cnt + 1 : 0;
        end
    end
endmodule

//--- sim/fde_fault_monitor.sv
`timescale 1ns/1ps

// Port checks on fault requests and lockup
module fde_fault_monitor (
    // Clock, reset and inputs
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire logic       i_err_vector_read,
    input wire logic [7:0] i_active_prio,
    input wire logic [2:0] i_active_kind,
    input wire logic       i_in_nmi,
    input wire logic       i_fault_ack,
    // Outputs
    input wire logic       o_fault_req,
    input wire logic [2:0] o_fault_kind,
    input wire logic [7:0] o_fault_prio,
    input wire logic       o_fault_escalated,
    input wire logic       o_lockup
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // Waiting request; hard fault raised inside the hard handler
    sequence s_waiting;
        o_fault_req && !i_fault_ack;
    endsequence
    sequence s_hard_in_hard;
        i_err_vector_read && i_active_kind == 3'h4;
    endsequence

    a_vector_to_hard: assert property (i_err_vector_read && i_active_kind == 3'h0 && !i_in_nmi
        |=> o_fault_kind == 3'h4 && o_fault_prio == 8'h00) else $error("vector error not hard");
    a_lock_enter: assert property (s_hard_in_hard |=> o_lockup) else $error("no lockup");
    a_lock_hold: assert property (o_lockup |=> o_lockup) else $error("lockup left");
    a_hard_prio_fixed: assert property (o_fault_req && o_fault_kind == 3'h4
        |-> o_fault_prio == 8'h00) else $error("hard prio moved");
    a_equal_pending: assert property (o_fault_req |-> o_fault_prio < i_active_prio)
        else $error("request not more urgent");
    a_hard_blocked: assert property (i_active_kind == 3'h4 || i_in_nmi |-> !o_fault_req)
        else $error("hard handler preempted");
    a_req_holds: assert property (s_waiting |=> o_fault_req || o_lockup || $changed(i_active_prio))
        else $error("request dropped");
    a_escalated_kind: assert property (o_fault_escalated |-> o_fault_kind == 3'h4)
        else $error("escalated not hard");
endmodule

bind fde_fault_unit fde_fault_monitor fde_fault_monitor_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_err_vector_read(i_err_vector_read),
    .i_active_prio(i_active_prio), .i_active_kind(i_active_kind), .i_in_nmi(i_in_nmi),
    .i_fault_ack(i_fault_ack), .o_fault_req(o_fault_req), .o_fault_kind(o_fault_kind),
    .o_fault_prio(o_fault_prio), .o_fault_escalated(o_fault_escalated), .o_lockup(o_lockup)
);

//--- sim/fde_fault_unit_tb_top.sv
`timescale 1ns/1ps

module fde_fault_unit_tb_top;
    logic        clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, nmi = 1'b0, ret = 1'b0;
    logic [7:0]  addr = 8'h00, act_prio, prio, o, p;
    logic [31:0] wdata = 32'h0, err_addr = 32'h0, rdata, r;
    logic [13:0] err = 14'h0;
    logic [2:0]  act_kind, kind, k;
    logic        ack, req, esc, lock;
    int          stall = 0, error_cnt = 0, samples_checked = 0;
    int          bitpos [1:13] = '{0, 1, 2, 4, 3, 0, 1, 2, 3, 8, 9, 0, 1};

    fde_fault_unit fde_fault_unit_inst (
        .i_clock(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(we),
        .i_reg_read(re), .o_reg_rdata(rdata), .i_err_vector_read(err[0]), .i_err_prefetch(err[1]),
        .i_err_exact_data(err[2]), .i_err_deferred_data(err[3]), .i_err_push(err[4]), .i_err_pop(err[5]),
        .i_bus_err_addr(err_addr), .i_err_undefined(err[6]), .i_err_set_switch(err[7]),
        .i_err_bad_return(err[8]), .i_err_coproc(err[9]), .i_err_unaligned(err[10]),
        .i_err_divzero(err[11]), .i_err_no_execute(err[12]), .i_err_mem_data(err[13]),
        .i_mem_err_addr(err_addr), .i_active_prio(act_prio), .i_active_kind(act_kind), .i_in_nmi(nmi),
        .i_fault_ack(ack), .o_fault_req(req), .o_fault_kind(kind), .o_fault_prio(prio),
        .o_fault_escalated(esc), .o_lockup(lock));
    fde_core_model fde_core_model_inst (.i_clock(clk), .i_rst(rst), .i_req(req), .i_kind(kind),
        .i_prio(prio), .i_stall(stall), .i_ret(ret), .o_ack(ack), .o_act_kind(act_kind), .o_act_prio(act_prio));

    // Clock and watchdog; the run needs a few hundred cycles
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done();
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {addr, wdata, we} <= {a, d, 1'b1};
        @(posedge clk);
        we <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        {addr, re} <= {a, 1'b1};
        @(posedge clk);
        re <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic pulse(input logic [13:0] m);
        @(posedge clk);
        err <= m;
        @(posedge clk);
        err <= 14'h0;
    endtask
    task automatic back();
        @(posedge clk);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
    endtask
    task automatic rst_seq();
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
    endtask
    // Raise a fault, wait for its request, compare it, let the model take it
    task automatic fault(input logic [13:0] m, input logic [2:0] ek, input logic [7:0] ep, input logic ee);
        int n;
        n = 0;
        pulse(m);
        do begin
            @(posedge clk);
            #1 n++;
        end while (req !== 1'b1 && n < 40);
        chk(req, 1'b1);
        chk(kind, ek);
        chk(prio, ep);
        chk(esc, ee);
        repeat (8) @(posedge clk);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        rst_seq();
        rd(8'h18, r);
        chk(r, 32'h0);
        rd(8'h24, r);
        chk(r, 32'h0);
        // Handlers disabled after reset, so everything escalates
        fault(14'h0040, 3'h4, 8'h00, 1'b1);
        pulse(14'h0001);
        repeat (20) @(posedge clk);
        rd(8'h00, r);
        chk({r[30], r[1]}, 2'b11);
        rd(8'h20, r);
        chk(r[0], lock);
        chk(lock, 1'b1);
        @(posedge clk);
        rst_seq();
        #1 chk(lock, 1'b0);
        // Vector read error from thread goes straight to hard, not escalated
        fault(14'h0001, 3'h4, 8'h00, 1'b0);
        rd(8'h00, r);
        chk(r, 32'h2);
        back();
        wr(8'h18, 32'h7);
        wr(8'h1c, 32'h80602040);
        // Every cause but the vector read alone, prompt and slow acceptance
        for (int i = 1; i < 14; i++) begin
            k = (i < 6) ? 3'h2 : (i < 12) ? 3'h3 : 3'h1;
            o = (i < 6) ? 8'h08 : (i < 12) ? 8'h0c : 8'h04;
            p = (k == 3'h2) ? 8'h20 : (k == 3'h3) ? 8'h60 : 8'h40;
            stall = (i % 2) * 3;
            err_addr <= 32'h4000_0100 + i;
            fault(14'h1 << i, k, p, 1'b0);
            rd(o, r);
            chk(r[bitpos[i]], 1'b1);
            if (i == 2 || i == 12) begin
                rd((i == 2) ? 8'h14 : 8'h10, r);
                chk(r, 32'h4000_0100 + i);
            end
            back();
            wr(o, 32'hffff_ffff);
            rd(o, r);
            chk(r, 32'h0);
        end
        stall = 0;
        fault(14'h0040, 3'h3, 8'h60, 1'b0);
        fault(14'h0800, 3'h4, 8'h00, 1'b1);
        back();
        fault(14'h0002, 3'h2, 8'h20, 1'b0);
        fault(14'h0040, 3'h4, 8'h00, 1'b1);
        back();
        fault(14'h0040, 3'h3, 8'h60, 1'b0);
        fault(14'h1000, 3'h1, 8'h40, 1'b0);
        back();
        // Push error while the bus handler runs stays a bus fault
        fault(14'h0002, 3'h2, 8'h20, 1'b0);
        pulse(14'h0010);
        repeat (4) @(posedge clk);
        #1 chk({req, esc, kind}, 5'h02);
        back();
        repeat (8) @(posedge clk);
        chk(act_kind, 3'h2);
        back();
        // Mask equal to usage priority holds the fault pending
        wr(8'h1c, 32'h60602040);
        pulse(14'h0040);
        repeat (6) @(posedge clk);
        #1 chk(req, 1'b0);
        wr(8'h1c, 32'h80602040);
        repeat (8) @(posedge clk);
        chk(act_kind, 3'h3);
        back();
        wr(8'h18, 32'h3);
        fault(14'h0200, 3'h4, 8'h00, 1'b1);
        back();
        wr(8'h18, 32'h7);
        wr(8'h0c, 32'hffff_ffff);
        fault(14'h0042, 3'h2, 8'h20, 1'b0);
        rd(8'h0c, r);
        chk(r[0], 1'b1);
        @(posedge clk);
        rst_seq();
        nmi <= 1'b1;
        pulse(14'h0040);
        repeat (4) @(posedge clk);
        #1 chk({req, lock}, 2'b01);
        test_done();
    end
endmodule
